// ===== hw/sp4_uart.sv
// Four-mode serial port: shift-register mode and three async modes.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Two mode bits pick sync 8-bit, async 10-bit, or async 11-bit frames.
// - Mode 2 bit rate is the system clock divided by 32 or 64.
// - Mode 0 shifts at the system clock divided by 4 or 12.
// - A power-control select bit makes control bit 7 the mode bit or error flag.
// - A bad stop bit sets the framing-error flag; only software clears it.
// - In mode 0 a cleared multiprocessor bit selects the divide-by-12 rate.
// - Mode 1 with multiprocessor bit set needs a valid stop for receive-done.
// - Modes 2/3 with multiprocessor bit set drop frames whose ninth bit is 0.
// - Reception starts only while the receive-enable bit is one; clearing it aborts async frames only, not mode 0.
// - Modes 2/3 send the stored ninth-bit value as the ninth data bit.
// - Received ninth bit holds the stop bit in mode 1, ninth bit in 2/3.
// - Transmit-done sets after bit 8 in mode 0, at stop start otherwise.
// - Receive-done sets after bit 8 in mode 0, mid-stop otherwise.
// - Data port reads give the receive register, writes load transmit data.
// - Serial interrupts reach the output only while the enable bit is set.
module sp4_uart (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                ce,
  input  wire sp4_pkg::sp4_bus_type bus,
  output logic [7:0]               rdata,
  input  wire logic                rate_tick,
  input  wire logic                rxd_sense,
  output logic                     rxd_drive,
  output logic                     rxd_oe,
  output logic                     txd,
  output logic                     irq
);
  import sp4_pkg::*;

  sp4_state_type s_r;
  sp4_state_type s_nxt;
  logic [1:0]    mode;
  logic          m0;
  logic [3:0]    per;
  logic [3:0]    half;
  logic          pre_tick;
  logic          tick;
  logic          start_tx;
  logic          ev_tx;
  logic          ev_rx;
  logic          ev_fe;
  logic          ninth;
  logic [7:0]    rx_byte;
  logic [3:0]    nbits;

  // The effective high mode bit is the stored one even while bit 7 shows
  // the error flag, so selecting the flag view never changes the mode.
  assign mode = {s_r.sm0, s_r.sm1};
  assign m0   = (mode == 2'b00);

  always_comb begin
    s_nxt    = s_r;
    ev_tx    = 1'b0;
    ev_rx    = 1'b0;
    ev_fe    = 1'b0;
    ninth    = 1'b0;
    rx_byte  = 8'h00;
    nbits    = (mode == 2'b01) ? SP4_BITS_M1 : SP4_BITS_M23;
    if (m0) begin
      per = s_r.mp ? SP4_M0_FAST : SP4_M0_SLOW;
    end else begin
      per = s_r.dbl ? SP4_M2_FAST : SP4_M2_SLOW;
    end
    half     = per >> 1;
    // A rate change can leave the prescaler above the new ratio; the
    // compare wraps it at once instead of running up to the 4-bit limit.
    pre_tick = (s_r.pre >= per - 4'h1);
    tick     = mode[0] ? rate_tick : pre_tick;
    start_tx = bus.wr && (bus.addr == SP4_DATA_ADDR) && !s_r.tx_busy &&
               !(m0 && (s_r.rx_st != RX_IDLE));

    if (bus.wr) begin
      case (bus.addr)
        SP4_CTRL_ADDR: begin
          if (s_r.sel) begin
            s_nxt.fe = bus.wdata[SP4_C_MODE_HI];
          end else begin
            s_nxt.sm0 = bus.wdata[SP4_C_MODE_HI];
          end
          s_nxt.sm1 = bus.wdata[SP4_C_MODE_LO];
          s_nxt.mp  = bus.wdata[SP4_C_MP];
          s_nxt.ren = bus.wdata[SP4_C_REN];
          s_nxt.tb8 = bus.wdata[SP4_C_TB8];
          s_nxt.rb8 = bus.wdata[SP4_C_RB8];
          s_nxt.ti  = bus.wdata[SP4_C_TI];
          s_nxt.ri  = bus.wdata[SP4_C_RI];
        end
        SP4_PWR_ADDR: begin
          s_nxt.dbl = bus.wdata[SP4_P_DOUBLE];
          s_nxt.sel = bus.wdata[SP4_P_SEL];
        end
        SP4_IEN_ADDR: begin
          s_nxt.es = bus.wdata[SP4_IE_ES];
        end
        SP4_IST_ADDR: begin
          s_nxt.ist = s_r.ist & ~bus.wdata[2:0];
        end
        SP4_IMSK_ADDR: begin
          s_nxt.imsk = bus.wdata[2:0];
        end
        default: begin
        end
      endcase
    end

    if (bus.rd) begin
      case (bus.addr)
        SP4_CTRL_ADDR: begin
          s_nxt.rdata = {s_r.sel ? s_r.fe : s_r.sm0, s_r.sm1, s_r.mp,
                         s_r.ren, s_r.tb8, s_r.rb8, s_r.ti, s_r.ri};
        end
        SP4_DATA_ADDR: s_nxt.rdata = s_r.rx_buf;
        SP4_PWR_ADDR:  s_nxt.rdata = {s_r.dbl, s_r.sel, 6'h00};
        SP4_IEN_ADDR:  s_nxt.rdata = {3'h0, s_r.es, 4'h0};
        SP4_IST_ADDR:  s_nxt.rdata = {5'h00, s_r.ist};
        SP4_IMSK_ADDR: s_nxt.rdata = {5'h00, s_r.imsk};
        default:       s_nxt.rdata = 8'h00;
      endcase
    end

    s_nxt.pre = pre_tick ? 4'h0 : s_r.pre + 4'h1;

    // Transmit side; a write while busy is dropped rather than queued.
    if (start_tx) begin
      s_nxt.tx_busy = 1'b1;
      s_nxt.tx_os   = 4'h0;
      if (m0) begin
        s_nxt.pre    = 4'h0;
        s_nxt.tx_sh  = {3'h7, bus.wdata};
        s_nxt.tx_cnt = SP4_BITS_M0;
      end else if (mode == 2'b01) begin
        s_nxt.tx_sh  = {2'h3, bus.wdata, 1'b0};
        s_nxt.tx_cnt = SP4_FRAME_10;
      end else begin
        s_nxt.tx_sh  = {1'b1, s_r.tb8, bus.wdata, 1'b0};
        s_nxt.tx_cnt = SP4_FRAME_11;
      end
    end else if (s_r.tx_busy) begin
      if (m0) begin
        if (pre_tick) begin
          s_nxt.tx_sh  = {1'b1, s_r.tx_sh[10:1]};
          s_nxt.tx_cnt = s_r.tx_cnt - 4'h1;
          if (s_r.tx_cnt == 4'h1) begin
            s_nxt.tx_busy = 1'b0;
            ev_tx         = 1'b1;
          end
        end
      end else if (tick) begin
        s_nxt.tx_os = s_r.tx_os + 4'h1;
        if (s_r.tx_os == SP4_OS_PER_BIT) begin
          s_nxt.tx_sh  = {1'b1, s_r.tx_sh[10:1]};
          s_nxt.tx_cnt = s_r.tx_cnt - 4'h1;
          if (s_r.tx_cnt == 4'h2) begin
            ev_tx = 1'b1;
          end
          if (s_r.tx_cnt == 4'h1) begin
            s_nxt.tx_busy = 1'b0;
          end
        end
      end
    end

    // Receive side.
    case (s_r.rx_st)
      RX_IDLE: begin
        if (s_r.ren) begin
          if (m0) begin
            if (!s_r.ri && !s_r.tx_busy && !start_tx) begin
              s_nxt.rx_st  = RX_DATA;
              s_nxt.rx_cnt = 4'h0;
              s_nxt.pre    = 4'h0;
            end
          end else if (!rxd_sense) begin
            s_nxt.rx_st = RX_START;
            s_nxt.rx_os = 4'h0;
          end
        end
      end
      RX_START: begin
        if (tick) begin
          s_nxt.rx_os = s_r.rx_os + 4'h1;
          if (s_r.rx_os == SP4_OS_CENTRE) begin
            s_nxt.rx_os  = 4'h0;
            s_nxt.rx_cnt = 4'h0;
            s_nxt.rx_st  = rxd_sense ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (m0) begin
          if (s_r.pre == half) begin
            s_nxt.rx_sh  = {rxd_sense, s_r.rx_sh[9:1]};
            s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
          end
          if (pre_tick && (s_r.rx_cnt == SP4_BITS_M0)) begin
            s_nxt.rx_buf = s_r.rx_sh[9:2];
            s_nxt.rx_st  = RX_IDLE;
            ev_rx        = 1'b1;
          end
        end else if (tick) begin
          s_nxt.rx_os = s_r.rx_os + 4'h1;
          if (s_r.rx_os == SP4_OS_PER_BIT) begin
            s_nxt.rx_sh  = {rxd_sense, s_r.rx_sh[9:1]};
            s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
            if (s_r.rx_cnt + 4'h1 == nbits) begin
              s_nxt.rx_st = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          s_nxt.rx_os = s_r.rx_os + 4'h1;
          if (s_r.rx_os == SP4_OS_PER_BIT) begin
            s_nxt.rx_st = RX_IDLE;
            if (mode == 2'b01) begin
              ninth   = rxd_sense;
              rx_byte = s_r.rx_sh[9:2];
            end else begin
              ninth   = s_r.rx_sh[9];
              rx_byte = s_r.rx_sh[8:1];
            end
            ev_fe = !rxd_sense;
            // A frame landing while the last one is unread is lost, so
            // software never sees a half-updated buffer.
            if (!s_r.ri && (!s_r.mp || ninth)) begin
              s_nxt.rx_buf = rx_byte;
              s_nxt.rb8    = ninth;
              ev_rx        = 1'b1;
            end
          end
        end
      end
      default: s_nxt.rx_st = RX_IDLE;
    endcase
    if (!s_r.ren && !m0) begin
      s_nxt.rx_st = RX_IDLE;
    end

    // Hardware sets come last so that they win over a same-cycle clear.
    if (ev_tx) begin
      s_nxt.ti              = 1'b1;
      s_nxt.ist[SP4_EV_TX]  = 1'b1;
    end
    if (ev_rx) begin
      s_nxt.ri              = 1'b1;
      s_nxt.ist[SP4_EV_RX]  = 1'b1;
    end
    if (ev_fe) begin
      s_nxt.fe              = 1'b1;
      s_nxt.ist[SP4_EV_FE]  = 1'b1;
    end

    if (m0 && (s_nxt.tx_busy || (s_nxt.rx_st != RX_IDLE))) begin
      s_nxt.txd = (s_nxt.pre >= half);
    end else begin
      s_nxt.txd = m0 ? 1'b1 : (!s_nxt.tx_busy || s_nxt.tx_sh[0]);
    end
    s_nxt.rxd_drive = s_nxt.tx_sh[0];
    s_nxt.rxd_oe    = m0 && s_nxt.tx_busy;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= SP4_RESET;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign rdata     = s_r.rdata;
  assign txd       = s_r.txd;
  assign rxd_drive = s_r.rxd_drive;
  assign rxd_oe    = s_r.rxd_oe;
  assign irq       = s_r.es && |(s_r.ist & s_r.imsk);

  logic ctl_wr;
  assign ctl_wr = bus.wr && (bus.addr == SP4_CTRL_ADDR);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_ti_sticky: assert property (
    s_r.ti && !(ctl_wr && !bus.wdata[SP4_C_TI]) |=> s_r.ti)
    else $error("transmit-done flag dropped without software");
  a_ri_sticky: assert property (
    s_r.ri && !(ctl_wr && !bus.wdata[SP4_C_RI]) |=> s_r.ri)
    else $error("receive-done flag dropped without software");
  a_fe_sticky: assert property (
    s_r.fe && !(ctl_wr && s_r.sel) |=> s_r.fe)
    else $error("framing-error flag dropped without software");
  a_rx_disabled: assert property (
    !s_r.ren && !m0 ##1 !s_r.ren |-> s_r.rx_st == RX_IDLE)
    else $error("receiver active while reception disabled");
  a_mp_ninth: assert property (
    $rose(s_r.ri) && !$past(ctl_wr) && mode[1] && s_r.mp |-> s_r.rb8)
    else $error("frame with ninth bit zero accepted");
  a_mp_stop: assert property (
    $rose(s_r.ri) && !$past(ctl_wr) && mode == 2'b01 && s_r.mp |-> s_r.rb8)
    else $error("mode 1 frame accepted without valid stop");
  a_tx_ninth: assert property (
    ce && start_tx && mode[1] |=> s_r.tx_sh[9] == $past(s_r.tb8))
    else $error("ninth transmit bit differs from stored value");
  // The prescaler may sit above a freshly lowered ratio for one cycle, so
  // the check is that it restarts once it reaches the end of its ratio.
  a_rate_div: assert property (
    ce && s_r.pre >= per - 4'h1 |=> s_r.pre == 4'h0)
    else $error("prescaler beyond its divide ratio");
  a_m0_slow: assert property (
    m0 && !s_r.mp && s_r.tx_busy && pre_tick |-> s_r.pre == 4'hb)
    else $error("mode 0 slow rate is not divide by 12");
  a_data_read: assert property (
    ce && bus.rd && bus.addr == SP4_DATA_ADDR |=> rdata == $past(s_r.rx_buf))
    else $error("data port read did not return receive register");
  a_irq_gate: assert property (
    irq |-> s_r.es)
    else $error("interrupt raised while serial enable is clear");
  a_fe_set: assert property (
    ce && s_r.rx_st == RX_STOP && tick && s_r.rx_os == SP4_OS_PER_BIT &&
    !rxd_sense |=> s_r.fe)
    else $error("bad stop bit did not set the framing-error flag");
  a_tx_idle: assert property (
    !s_r.tx_busy && !m0 && $past(!m0) |-> txd)
    else $error("async transmit line not idle high");
  // Mode changes in mid-frame are undefined, so a control write just
  // before is left out of the check.
  a_m0_drive: assert property (
    m0 && s_r.tx_busy && !$past(ctl_wr) |-> rxd_oe)
    else $error("mode 0 transmit not driving the data pin");

  c_m1_rx: cover property ($rose(s_r.ri) && mode == 2'b01);
  c_m3_tx: cover property ($rose(s_r.ti) && mode == 2'b11);
  c_frame_err: cover property ($rose(s_r.fe));
  c_m0_rx: cover property ($rose(s_r.ri) && m0);
  c_m0_slow: cover property ($rose(s_r.ti) && m0 && !s_r.mp);
endmodule // sp4_uart
`default_nettype wire

// ===== hw/sp4_pkg.sv
// Constants and types of the four-mode serial port.
package sp4_pkg;
  localparam logic [7:0] SP4_CTRL_ADDR = 8'h98;
  localparam logic [7:0] SP4_DATA_ADDR = 8'h99;
  localparam logic [7:0] SP4_PWR_ADDR  = 8'h87;
  localparam logic [7:0] SP4_IEN_ADDR  = 8'ha8;
  localparam logic [7:0] SP4_IST_ADDR  = 8'hc0;
  localparam logic [7:0] SP4_IMSK_ADDR = 8'hc1;
  localparam int SP4_C_MODE_HI = 7;
  localparam int SP4_C_MODE_LO = 6;
  localparam int SP4_C_MP      = 5;
  localparam int SP4_C_REN     = 4;
  localparam int SP4_C_TB8     = 3;
  localparam int SP4_C_RB8     = 2;
  localparam int SP4_C_TI      = 1;
  localparam int SP4_C_RI      = 0;
  localparam int SP4_P_DOUBLE  = 7;
  localparam int SP4_P_SEL     = 6;
  localparam int SP4_IE_ES     = 4;
  localparam int SP4_EV_TX     = 0;
  localparam int SP4_EV_RX     = 1;
  localparam int SP4_EV_FE     = 2;
  localparam logic [3:0] SP4_OS_PER_BIT = 4'hf;
  localparam logic [3:0] SP4_OS_CENTRE  = 4'h7;
  localparam int SP4_M0_FAST_DIV = 4;
  localparam int SP4_M0_SLOW_DIV = 12;
  localparam int SP4_M2_FAST_DIV = 32;
  localparam int SP4_M2_SLOW_DIV = 64;
  localparam int SP4_OS_RATIO    = 16;
  localparam logic [3:0] SP4_M0_FAST = 4'(SP4_M0_FAST_DIV);
  localparam logic [3:0] SP4_M0_SLOW = 4'(SP4_M0_SLOW_DIV);
  localparam logic [3:0] SP4_M2_FAST = 4'(SP4_M2_FAST_DIV / SP4_OS_RATIO);
  localparam logic [3:0] SP4_M2_SLOW = 4'(SP4_M2_SLOW_DIV / SP4_OS_RATIO);
  localparam logic [3:0] SP4_BITS_M0  = 4'h8;
  localparam logic [3:0] SP4_BITS_M1  = 4'h8;
  localparam logic [3:0] SP4_BITS_M23 = 4'h9;
  localparam logic [3:0] SP4_FRAME_10 = 4'ha;
  localparam logic [3:0] SP4_FRAME_11 = 4'hb;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } sp4_rx_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sp4_bus_type;

  typedef struct packed {
    logic             sm0;
    logic             fe;
    logic             sm1;
    logic             mp;
    logic             ren;
    logic             tb8;
    logic             rb8;
    logic             ti;
    logic             ri;
    logic             sel;
    logic             dbl;
    logic             es;
    logic [2:0]       ist;
    logic [2:0]       imsk;
    logic [7:0]       rx_buf;
    logic [7:0]       rdata;
    logic [3:0]       pre;
    logic             tx_busy;
    logic [10:0]      tx_sh;
    logic [3:0]       tx_cnt;
    logic [3:0]       tx_os;
    sp4_rx_state_type rx_st;
    logic [9:0]       rx_sh;
    logic [3:0]       rx_cnt;
    logic [3:0]       rx_os;
    logic             txd;
    logic             rxd_drive;
    logic             rxd_oe;
  } sp4_state_type;

  localparam sp4_state_type SP4_RESET = '{
    rx_st:   RX_IDLE,
    txd:     1'b1,
    default: '0
  };
endpackage : sp4_pkg

// ===== dv/sp4_remote.sv
// Remote serial device that sends and captures asynchronous frames.
`timescale 1ns/1ps
`default_nettype none
module sp4_remote (
  input  wire logic clk,
  input  wire logic txd,
  output var logic  rxd
);
  // The line idles high between frames, so no stale level is left behind.
  initial rxd = 1'b1;

  task automatic send(input logic [8:0] d, input int nb, input int per,
                      input logic stop);
    rxd <= 1'b0;
    repeat (per) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      repeat (per) @(posedge clk);
    end
    // A bad stop bit is cut short so its tail is not taken as a new start.
    rxd <= stop;
    repeat (stop ? per : per * 3 / 4) @(posedge clk);
    rxd <= 1'b1;
    repeat (per) @(posedge clk);
  endtask

  // Samples mid-bit; a frame that never starts leaves idle-high ones behind after the 400-cycle wait.
  task automatic grab(output logic [9:0] b, input int nb, input int per);
    b = '0;
    for (int i = 0; i < 400 && txd; i++) @(posedge clk);
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i <= nb; i++) begin
      repeat (per) @(posedge clk);
      b[i] = txd;
    end
  endtask
endmodule // sp4_remote
`default_nettype wire

// ===== dv/sp4_uart_tb_top.sv
// Bench for the four-mode serial port: register tasks and frame tests.
`timescale 1ns/1ps
`default_nettype none
module sp4_uart_tb_top;
  import sp4_pkg::*;
  logic        clk;
  logic        srst;
  logic        ce;
  sp4_bus_type bus;
  logic [7:0]  rdata;
  logic        rate_tick;
  logic        rem_rxd;
  logic        rxd_line;
  logic        rxd_drive;
  logic        rxd_oe;
  logic        txd;
  logic        irq;
  logic [9:0]  b;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;

  assign rxd_line = rxd_oe ? rxd_drive : rem_rxd;

  sp4_uart u_dut (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .bus       (bus),
    .rdata     (rdata),
    .rate_tick (rate_tick),
    .rxd_sense (rxd_line),
    .rxd_drive (rxd_drive),
    .rxd_oe    (rxd_oe),
    .txd       (txd),
    .irq       (irq)
  );

  sp4_remote u_rem (
    .clk (clk),
    .txd (txd),
    .rxd (rem_rxd)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // A tick every second clock gives 32 clocks per bit in modes 1 and 3.
  always @(posedge clk) begin
    rate_tick <= ~rate_tick & ~srst;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // A spare cycle after each access keeps strobes from being reassigned.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    logic [7:0] d;
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
    @(posedge clk);
    chk(d & m, e);
  endtask

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    bus = '0;
    rate_tick = 1'b0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'h00);
    rdc(8'h55, 8'hff, 8'h00);
    wr(SP4_IMSK_ADDR, 8'h07);
    wr(SP4_PWR_ADDR, 8'h80);
    wr(SP4_CTRL_ADDR, 8'h88);
    fork
      u_rem.grab(b, 9, 32);
      wr(SP4_DATA_ADDR, 8'ha5);
    join
    chk(b[7:0], 8'ha5);
    chk({7'h00, b[8]}, 8'h01);
    chk({7'h00, b[9]}, 8'h01);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'h8a);
    chk({7'h00, irq}, 8'h00);
    wr(SP4_IEN_ADDR, 8'h10);
    chk({7'h00, irq}, 8'h01);
    wr(SP4_IST_ADDR, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(SP4_CTRL_ADDR, 8'hb0);
    u_rem.send(9'h03c, 9, 32, 1'b1);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'hb0);
    u_rem.send(9'h1c3, 9, 32, 1'b1);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'hb5);
    rdc(SP4_DATA_ADDR, 8'hff, 8'hc3);
    wr(SP4_PWR_ADDR, 8'h00);
    wr(SP4_CTRL_ADDR, 8'h70);
    wr(SP4_PWR_ADDR, 8'h40);
    u_rem.send(9'h05a, 8, 32, 1'b0);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'hf0);
    wr(SP4_PWR_ADDR, 8'h00);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'h70);
    wr(SP4_CTRL_ADDR, 8'h50);
    u_rem.send(9'h096, 8, 32, 1'b1);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'h55);
    rdc(SP4_DATA_ADDR, 8'hff, 8'h96);
    wr(SP4_PWR_ADDR, 8'h40);
    rdc(SP4_CTRL_ADDR, 8'h80, 8'h80);
    wr(SP4_CTRL_ADDR, 8'h40);
    u_rem.send(9'h033, 8, 32, 1'b1);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'h40);
    rdc(SP4_DATA_ADDR, 8'hff, 8'h96);
    fork
      u_rem.grab(b, 8, 32);
      wr(SP4_DATA_ADDR, 8'h69);
    join
    chk(b[7:0], 8'h69);
    chk({7'h00, b[8]}, 8'h01);
    rdc(SP4_CTRL_ADDR, 8'h02, 8'h02);
    repeat (32) @(posedge clk);
    wr(SP4_PWR_ADDR, 8'h00);
    wr(SP4_CTRL_ADDR, 8'h20);
    wr(SP4_DATA_ADDR, 8'h5a);
    @(negedge clk);
    chk({6'h00, rxd_oe, rxd_drive}, 8'h02);
    @(posedge clk);
    repeat (40) @(posedge clk);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'h22);
    wr(SP4_CTRL_ADDR, 8'h00);
    wr(SP4_DATA_ADDR, 8'hc3);
    repeat (50) @(posedge clk);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'h00);
    repeat (60) @(posedge clk);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'h02);
    wr(SP4_CTRL_ADDR, 8'h30);
    repeat (40) @(posedge clk);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'h31);
    rdc(SP4_DATA_ADDR, 8'hff, 8'hff);
    wr(SP4_CTRL_ADDR, 8'hd8);
    fork
      u_rem.grab(b, 9, 32);
      wr(SP4_DATA_ADDR, 8'h3c);
    join
    chk(b[7:0], 8'h3c);
    chk({7'h00, b[8]}, 8'h01);
    chk({7'h00, b[9]}, 8'h01);
    rdc(SP4_CTRL_ADDR, 8'hff, 8'hda);
    finish_test();
  end
endmodule // sp4_uart_tb_top
`default_nettype wire
